// ===== common/dsas_cfg.svh
// register offsets, field positions and reset values of the sequencer
// assumes byte addresses on a 32-bit AXI4-Lite slave, one word a register
`ifndef DSAS_CFG_SVH
`define DSAS_CFG_SVH
// --------------------------------------------------------------------
// map: converter k at k * 0x40, power control at 0x80
// --------------------------------------------------------------------
`define DSAS_GLOBAL_BIT 7
`define DSAS_CONV_BIT 6
`define DSAS_IDX_CTRL 4'h0
`define DSAS_IDX_SEL 4'h1
`define DSAS_IDX_STAT 4'h2
`define DSAS_IDX_LIMIT 4'h3
`define DSAS_IDX_RES0 4'h4
`define DSAS_IDX_RES3 4'h7
`define DSAS_IDX_TRIM 4'h8
`define DSAS_IDX_PWR 5'h00
// --------------------------------------------------------------------
// fields and values
// --------------------------------------------------------------------
`define DSAS_HI_RST 8'hff
`define DSAS_LO_RST 8'h00
`define DSAS_TRIM_RST 32'h80808080
`define DSAS_SETTLE 2'h3
`define DSAS_PWR_IDLE 2'h1
`define DSAS_PWR_DOWN 2'h2
`define DSAS_SRC_TEMP 2'h2
`define DSAS_RESP_OKAY 2'h0
`define DSAS_RESP_SLVERR 2'h2
`endif

// ===== common/dsas_pkg.sv
// types of the dual converter sequencer: modes, states, state records
// assumes dsas_cfg.svh supplies all numeric constants
package dsas_pkg;
    typedef enum logic [2:0] {
        DSAS_FIX_ONE, DSAS_FIX_RUN, DSAS_SCAN_ONE,
        DSAS_SCAN_RUN, DSAS_DUAL_RUN, DSAS_STEP
    } dsas_mode_t;
    typedef enum logic [1:0] {
        DSAS_SRC_TIMER, DSAS_SRC_NOW, DSAS_SRC_EDGE, DSAS_SRC_DUAL
    } dsas_src_t;
    typedef enum logic [1:0] {
        DSAS_IDLE, DSAS_SAMPLE, DSAS_CONV
    } dsas_state_t;
    typedef struct packed {
        logic en;
        dsas_mode_t mode;
        dsas_src_t src;
        logic int_ie;
        logic bnd_ie;
        logic bnd_out;
        logic amp_en;
        logic [1:0] gain;
        logic [2:0] div;
        logic dac_mode;
        logic [3:0] mask;
        logic [1:0] ch_a;
        logic [1:0] ch_b;
        logic [1:0] amp_ch;
        logic [1:0] amp_src;
        logic [7:0] hi;
        logic [7:0] lo;
        logic [3:0][7:0] res;
        logic [3:0][7:0] trim;
        logic done_f;
        logic bnd_f;
        logic [3:0] hit;
        dsas_state_t st;
        logic [3:0] pend;
        logic [1:0] ch;
        logic [1:0] slot;
        logic [7:0] sar;
        logic [2:0] bitn;
        logic [2:0] divc;
        logic [1:0] settle;
        logic early;
        logic [1:0] cmp_s;
    } dsas_conv_t;
    typedef struct packed {
        dsas_conv_t [1:0] cv;
        logic aw_v;
        logic [7:0] aw_a;
        logic w_v;
        logic [31:0] w_d;
        logic [3:0] w_s;
        logic b_v;
        logic [1:0] b_r;
        logic r_v;
        logic [31:0] r_d;
        logic [1:0] r_r;
        logic [1:0] pwr;
        logic [2:0] pin_s;
        logic wake;
    } dsas_top_t;
    // one converter's view of its analog front end
    typedef struct packed {
        logic [1:0] mux;
        logic sample;
        logic [7:0] dac;
        logic dac_out;
        logic amp_on;
        logic amp_unity;
        logic [1:0] gain;
        logic [7:0] trim;
        logic [1:0] amp_src;
        logic temp_on;
        logic active;
    } dsas_fe_t;
endpackage

// ===== hdl/dsas_top.sv
// dual 8-bit successive approximation sequencer with AXI4-Lite registers
// assumes an analog front end per converter: mux, hold, DAC, comparator
// Summary of operation
// RULE_01: fixed single mode converts one input once into its own slot.
// RULE_02: fixed continuous mode rotates results over four slots until stopped.
// RULE_03: scan single converts each chosen input once, flags after all.
// RULE_04: scan continuous restarts at first chosen input after each pass.
// RULE_05: dual mode alternates two inputs into slots 0 to 3.
// RULE_06: step mode converts one chosen input per start, flags each.
// RULE_07: in fixed single and scan modes amplifier follows converted input.
// RULE_08: other modes pick amplifier input freely; others convert at unity.
// RULE_09: amplifier gain is two, four, eight or sixteen on one input.
// RULE_10: trim registers load factory defaults at reset.
// RULE_11: first amplifier input shares reference, temperature and input three.
// RULE_12: timer overflow starts a conversion; ignored while one runs.
// RULE_13: writing the immediate start source starts a conversion at once.
// RULE_14: either edge of trigger pin starts; ignored while converting.
// RULE_15: dual start launches both converters together from either one.
// RULE_16: software sets both converters alike before dual start.
// RULE_17: limit check inside or outside bounds, off when its enable clears.
// RULE_18: outside check tests top nibble early, full byte otherwise.
// RULE_19: limit hit flags mark the channel that raised the limit flag.
// RULE_20: in DAC mode slot three drives the channel three pin.
// RULE_21: converter clock divider ratio one to eight.
// RULE_22: idle keeps converting and wakes; power-down stops everything.
// RULE_23: two independent converters, four inputs and four slots each.
// RULE_24: sticky flags cleared by software; request needs flag and enable.
`timescale 1ns/100ps
`include "dsas_cfg.svh"

module dsas_top (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [7:0] s_axi_araddr,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    input wire logic timer_ovf,
    input wire logic edge_trigger_input_pin,
    input wire logic [1:0] comp_in,
    output dsas_pkg::dsas_fe_t [1:0] fe,
    output logic adc_irq,
    output logic wake_req
);
    dsas_pkg::dsas_top_t s_reg;
    dsas_pkg::dsas_top_t s_next;

    // --------------------------------------------------------------------
    // helpers
    // --------------------------------------------------------------------
    function automatic logic [1:0] dsas_low(input logic [3:0] m);
        if (m[0]) begin
            return 2'h0;
        end else if (m[1]) begin
            return 2'h1;
        end else if (m[2]) begin
            return 2'h2;
        end
        return 2'h3;
    endfunction

    function automatic logic dsas_map(input logic [7:0] a);
        if (a[1:0] != 2'h0) begin
            return 1'b0;
        end else if (a[`DSAS_GLOBAL_BIT]) begin
            return a[6:2] == `DSAS_IDX_PWR;
        end
        return a[5:2] <= `DSAS_IDX_TRIM;
    endfunction

    function automatic logic [31:0] dsas_rd(
        input dsas_pkg::dsas_top_t s,
        input logic [7:0] a
    );
        dsas_pkg::dsas_conv_t c;
        logic [31:0] d;
        c = s.cv[a[`DSAS_CONV_BIT]];
        d = 32'h0;
        if (!dsas_map(a)) begin
            d = 32'h0;
        end else if (a[`DSAS_GLOBAL_BIT]) begin
            d[1:0] = s.pwr;
        end else begin
            case (a[5:2])
                `DSAS_IDX_CTRL: d[15:0] = {c.dac_mode, c.div, c.gain,
                    c.amp_en, c.bnd_out, c.bnd_ie, c.int_ie, c.src,
                    c.mode, c.en};
                `DSAS_IDX_SEL: d[11:0] = {c.amp_src, c.amp_ch, c.ch_b,
                    c.ch_a, c.mask};
                `DSAS_IDX_STAT: d[7:0] = {c.hit, 1'b0,
                    c.st != dsas_pkg::DSAS_IDLE, c.bnd_f, c.done_f};
                `DSAS_IDX_LIMIT: d[15:0] = {c.hi, c.lo};
                `DSAS_IDX_TRIM: d = c.trim;
                default: d[7:0] = c.res[a[3:2]];
            endcase
        end
        return d;
    endfunction

    // --------------------------------------------------------------------
    // next state
    // --------------------------------------------------------------------
    always_comb begin
        logic [31:0] m;
        logic [31:0] wd;
        logic [1:0] now_go;
        logic dual_go;
        logic pin_ev;
        logic k;
        logic up;
        logic tick;
        logic trig;
        logic fin;
        logic lim;
        logic [7:0] r;
        logic [3:0] p;
        m = 32'h0;
        wd = 32'h0;
        now_go = 2'b00;
        dual_go = 1'b0;
        k = s_reg.aw_a[`DSAS_CONV_BIT];
        up = 1'b0;
        tick = 1'b0;
        trig = 1'b0;
        fin = 1'b0;
        lim = 1'b0;
        r = 8'h0;
        p = 4'h0;
        s_next = s_reg;
        s_next.wake = 1'b0;
        s_next.pin_s = {s_reg.pin_s[1:0], edge_trigger_input_pin};
        // sync stage 1 feeds stage 2 only; edge taken from stages 2 and 3
        pin_ev = s_reg.pin_s[2] ^ s_reg.pin_s[1]; // RULE_14

        // ---------------- register bus ----------------
        if (s_axi_awvalid && !s_reg.aw_v) begin
            s_next.aw_v = 1'b1;
            s_next.aw_a = s_axi_awaddr;
        end
        if (s_axi_wvalid && !s_reg.w_v) begin
            s_next.w_v = 1'b1;
            s_next.w_d = s_axi_wdata;
            s_next.w_s = s_axi_wstrb;
        end
        if (s_reg.b_v && s_axi_bready) begin
            s_next.b_v = 1'b0;
        end
        if (s_reg.r_v && s_axi_rready) begin
            s_next.r_v = 1'b0;
        end
        if (s_axi_arvalid && !s_reg.r_v) begin
            s_next.r_v = 1'b1;
            s_next.r_d = dsas_rd(s_reg, s_axi_araddr);
            s_next.r_r = dsas_map(s_axi_araddr) ? `DSAS_RESP_OKAY
                                                : `DSAS_RESP_SLVERR;
        end
        if (s_reg.aw_v && s_reg.w_v && !s_reg.b_v) begin
            s_next.aw_v = 1'b0;
            s_next.w_v = 1'b0;
            s_next.b_v = 1'b1;
            s_next.b_r = dsas_map(s_reg.aw_a) ? `DSAS_RESP_OKAY
                                              : `DSAS_RESP_SLVERR;
            m = {{8{s_reg.w_s[3]}}, {8{s_reg.w_s[2]}},
                 {8{s_reg.w_s[1]}}, {8{s_reg.w_s[0]}}};
            wd = (dsas_rd(s_reg, s_reg.aw_a) & ~m) | (s_reg.w_d & m);
            if (!dsas_map(s_reg.aw_a)) begin
                wd = 32'h0;
            end else if (s_reg.aw_a[`DSAS_GLOBAL_BIT]) begin
                s_next.pwr = wd[1:0];
            end else begin
                case (s_reg.aw_a[5:2])
                    `DSAS_IDX_CTRL: begin
                        {s_next.cv[k].dac_mode, s_next.cv[k].div,
                         s_next.cv[k].gain, s_next.cv[k].amp_en,
                         s_next.cv[k].bnd_out, s_next.cv[k].bnd_ie,
                         s_next.cv[k].int_ie} = wd[15:6];
                        s_next.cv[k].src = dsas_pkg::dsas_src_t'(wd[5:4]);
                        s_next.cv[k].mode = dsas_pkg::dsas_mode_t'(wd[3:1]);
                        s_next.cv[k].en = wd[0];
                        if (wd[0] && wd[5:4] == 2'(dsas_pkg::DSAS_SRC_NOW)) begin
                            now_go[k] = 1'b1; // RULE_13
                        end
                        if (wd[0] && wd[5:4] == 2'(dsas_pkg::DSAS_SRC_DUAL)) begin
                            dual_go = 1'b1; // RULE_15
                        end
                    end
                    `DSAS_IDX_SEL: begin
                        {s_next.cv[k].amp_src, s_next.cv[k].amp_ch,
                         s_next.cv[k].ch_b, s_next.cv[k].ch_a} = wd[11:4];
                        s_next.cv[k].mask = wd[3:0];
                    end
                    `DSAS_IDX_STAT: begin
                        // write one to clear; a same-cycle set below wins
                        if (s_reg.w_d[0] && s_reg.w_s[0]) begin
                            s_next.cv[k].done_f = 1'b0; // RULE_24
                        end
                        if (s_reg.w_d[1] && s_reg.w_s[0]) begin
                            s_next.cv[k].bnd_f = 1'b0;
                        end
                        if (s_reg.w_s[0]) begin
                            s_next.cv[k].hit = s_reg.cv[k].hit
                                               & ~s_reg.w_d[7:4];
                        end
                    end
                    `DSAS_IDX_LIMIT: begin
                        {s_next.cv[k].hi, s_next.cv[k].lo} = wd[15:0];
                    end
                    `DSAS_IDX_TRIM: s_next.cv[k].trim = wd; // RULE_10
                    `DSAS_IDX_RES3: begin
                        s_next.cv[k].res[3] = wd[7:0]; // RULE_20
                    end
                    default: begin
                    end
                endcase
            end
        end

        // ---------------- both converters ----------------
        for (int i = 0; i < 2; i++) begin // RULE_23
            s_next.cv[i].cmp_s = {s_reg.cv[i].cmp_s[0], comp_in[i]};
            // ratio is div + 1; software keeps the result in range
            tick = s_reg.cv[i].divc == s_next.cv[i].div; // RULE_21
            s_next.cv[i].divc = tick ? 3'h0 : 3'(s_reg.cv[i].divc + 3'h1);
            if (s_reg.cv[i].settle != 2'h0) begin
                s_next.cv[i].settle = 2'(s_reg.cv[i].settle - 2'h1);
            end
            case (s_next.cv[i].src)
                dsas_pkg::DSAS_SRC_TIMER: trig = timer_ovf; // RULE_12
                dsas_pkg::DSAS_SRC_NOW: trig = now_go[i];
                dsas_pkg::DSAS_SRC_EDGE: trig = pin_ev;
                default: trig = dual_go;
            endcase
            fin = 1'b0;
            r = s_reg.cv[i].sar;
            case (s_reg.cv[i].st)
                // starts are taken only here, so triggers during a
                // conversion are dropped, not queued
                dsas_pkg::DSAS_IDLE: begin
                    if (trig) begin // RULE_12 RULE_14
                        s_next.cv[i].slot = 2'h0;
                        s_next.cv[i].st = dsas_pkg::DSAS_SAMPLE;
                        s_next.cv[i].ch = s_next.cv[i].ch_a;
                        p = (s_reg.cv[i].pend == 4'h0) ? s_next.cv[i].mask
                                                       : s_reg.cv[i].pend;
                        if (s_next.cv[i].mode inside {dsas_pkg::DSAS_SCAN_ONE,
                                dsas_pkg::DSAS_SCAN_RUN, dsas_pkg::DSAS_STEP})
                                begin
                            s_next.cv[i].pend = p;
                            s_next.cv[i].ch = dsas_low(p);
                            if (p == 4'h0) begin
                                s_next.cv[i].st = dsas_pkg::DSAS_IDLE;
                            end
                        end
                    end
                end
                dsas_pkg::DSAS_SAMPLE: begin
                    if (tick) begin
                        s_next.cv[i].st = dsas_pkg::DSAS_CONV;
                        s_next.cv[i].sar = 8'h80;
                        s_next.cv[i].bitn = 3'h7;
                        s_next.cv[i].early = 1'b0;
                        s_next.cv[i].settle = `DSAS_SETTLE;
                    end
                end
                dsas_pkg::DSAS_CONV: begin
                    // wait out the comparator synchroniser before deciding
                    if (tick && s_reg.cv[i].settle == 2'h0) begin
                        if (!s_reg.cv[i].cmp_s[1]) begin
                            r = r & ~(8'h01 << s_reg.cv[i].bitn);
                        end
                        s_next.cv[i].sar = r;
                        if (s_reg.cv[i].bitn == 3'h4 && s_reg.cv[i].bnd_ie
                                && s_reg.cv[i].bnd_out && (r[7:4] >
                                s_reg.cv[i].hi[7:4] || r[7:4] <
                                s_reg.cv[i].lo[7:4])) begin
                            s_next.cv[i].early = 1'b1; // RULE_18
                            s_next.cv[i].bnd_f = 1'b1;
                            s_next.cv[i].hit[s_reg.cv[i].ch] = 1'b1;
                        end
                        if (s_reg.cv[i].bitn == 3'h0) begin
                            fin = 1'b1;
                        end else begin
                            s_next.cv[i].sar = r | (8'h01 <<
                                3'(s_reg.cv[i].bitn - 3'h1));
                            s_next.cv[i].bitn = 3'(s_reg.cv[i].bitn - 3'h1);
                            s_next.cv[i].settle = `DSAS_SETTLE;
                        end
                    end
                end
                default: s_next.cv[i].st = dsas_pkg::DSAS_IDLE;
            endcase

            if (fin) begin
                lim = s_reg.cv[i].bnd_out ? (r > s_reg.cv[i].hi
                    || r < s_reg.cv[i].lo) : (r >= s_reg.cv[i].lo
                    && r <= s_reg.cv[i].hi); // RULE_17
                if (lim && s_reg.cv[i].bnd_ie && !s_reg.cv[i].early) begin
                    s_next.cv[i].bnd_f = 1'b1; // RULE_18
                    s_next.cv[i].hit[s_reg.cv[i].ch] = 1'b1; // RULE_19
                end
                s_next.cv[i].res[s_reg.cv[i].ch] = r;
                s_next.cv[i].st = dsas_pkg::DSAS_SAMPLE;
                p = s_reg.cv[i].pend & ~(4'h1 << s_reg.cv[i].ch);
                s_next.cv[i].pend = p;
                case (s_reg.cv[i].mode)
                    dsas_pkg::DSAS_FIX_RUN, dsas_pkg::DSAS_DUAL_RUN: begin
                        s_next.cv[i].res = s_reg.cv[i].res;
                        s_next.cv[i].res[s_reg.cv[i].slot] = r; // RULE_02
                        s_next.cv[i].slot = 2'(s_reg.cv[i].slot + 2'h1);
                        s_next.cv[i].done_f = s_next.cv[i].done_f
                                              | (s_reg.cv[i].slot == 2'h3);
                        if (s_reg.cv[i].mode == dsas_pkg::DSAS_DUAL_RUN) begin
                            s_next.cv[i].ch = s_reg.cv[i].slot[0]
                                ? s_reg.cv[i].ch_a : s_reg.cv[i].ch_b; // RULE_05
                        end
                    end
                    dsas_pkg::DSAS_SCAN_ONE, dsas_pkg::DSAS_SCAN_RUN: begin
                        s_next.cv[i].ch = dsas_low(p);
                        if (p == 4'h0) begin
                            s_next.cv[i].done_f = 1'b1; // RULE_03
                            s_next.cv[i].pend = s_reg.cv[i].mask;
                            s_next.cv[i].ch = dsas_low(s_reg.cv[i].mask);
                            if (s_reg.cv[i].mode == dsas_pkg::DSAS_SCAN_ONE)
                                    begin
                                s_next.cv[i].pend = 4'h0;
                                s_next.cv[i].st = dsas_pkg::DSAS_IDLE;
                            end
                        end // RULE_04
                    end
                    dsas_pkg::DSAS_STEP: begin
                        s_next.cv[i].done_f = 1'b1; // RULE_06
                        s_next.cv[i].st = dsas_pkg::DSAS_IDLE;
                    end
                    default: begin
                        s_next.cv[i].done_f = 1'b1; // RULE_01
                        s_next.cv[i].st = dsas_pkg::DSAS_IDLE;
                    end
                endcase
                if (s_reg.pwr == `DSAS_PWR_IDLE && s_reg.cv[i].int_ie
                        && s_next.cv[i].done_f && !s_reg.cv[i].done_f) begin
                    s_next.wake = 1'b1; // RULE_22
                end
            end
            // clearing enable ends a run; power-down halts it too
            if (!s_next.cv[i].en || s_next.pwr[1]) begin // RULE_22
                s_next.cv[i].st = dsas_pkg::DSAS_IDLE;
                s_next.cv[i].pend = 4'h0;
            end
        end
    end

    // --------------------------------------------------------------------
    // state register
    // --------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            s_reg <= '0;
            for (int i = 0; i < 2; i++) begin
                s_reg.cv[i].trim <= `DSAS_TRIM_RST; // RULE_10
                s_reg.cv[i].hi <= `DSAS_HI_RST;
                s_reg.cv[i].lo <= `DSAS_LO_RST;
            end
        end else begin
            s_reg <= s_next;
        end
    end

    // --------------------------------------------------------------------
    // outputs
    // --------------------------------------------------------------------
    assign s_axi_awready = !s_reg.aw_v;
    assign s_axi_wready = !s_reg.w_v;
    assign s_axi_bvalid = s_reg.b_v;
    assign s_axi_bresp = s_reg.b_r;
    assign s_axi_arready = !s_reg.r_v;
    assign s_axi_rvalid = s_reg.r_v;
    assign s_axi_rdata = s_reg.r_d;
    assign s_axi_rresp = s_reg.r_r;
    assign wake_req = s_reg.wake;

    always_comb begin
        logic on;
        logic [1:0] ach;
        adc_irq = 1'b0;
        on = !s_reg.pwr[1];
        ach = 2'h0;
        for (int i = 0; i < 2; i++) begin
            adc_irq = adc_irq | (s_reg.cv[i].done_f & s_reg.cv[i].int_ie)
                | (s_reg.cv[i].bnd_f & s_reg.cv[i].bnd_ie); // RULE_24
            ach = (s_reg.cv[i].mode inside {dsas_pkg::DSAS_FIX_ONE,
                dsas_pkg::DSAS_SCAN_ONE, dsas_pkg::DSAS_SCAN_RUN})
                ? s_reg.cv[i].ch : s_reg.cv[i].amp_ch; // RULE_07 RULE_08
            fe[i].mux = s_reg.cv[i].ch;
            fe[i].sample = s_reg.cv[i].st == dsas_pkg::DSAS_SAMPLE;
            fe[i].dac = (s_reg.cv[i].dac_mode
                && s_reg.cv[i].st == dsas_pkg::DSAS_IDLE)
                ? s_reg.cv[i].res[3] : s_reg.cv[i].sar;
            fe[i].dac_out = s_reg.cv[i].dac_mode && on; // RULE_20
            fe[i].amp_on = s_reg.cv[i].amp_en && on;
            fe[i].amp_unity = !s_reg.cv[i].amp_en
                || s_reg.cv[i].ch != ach; // RULE_08
            fe[i].gain = s_reg.cv[i].gain; // RULE_09
            fe[i].trim = s_reg.cv[i].trim[s_reg.cv[i].gain];
            // only the first amplifier has the shared input
            fe[i].amp_src = (i == 0) ? s_reg.cv[i].amp_src : 2'h0; // RULE_11
            fe[i].temp_on = (i == 0) && on
                && s_reg.cv[i].amp_src == `DSAS_SRC_TEMP;
            fe[i].active = s_reg.cv[i].en && on; // RULE_22
        end
    end
endmodule // dsas_top

// ===== verif/dsas_top_checker.sv
// port assertions of the sequencer, bound into dsas_top
// assumes the synchronous active-high reset of the top module
`timescale 1ns/100ps
module dsas_top_checker (
    input logic clk_sys, reset, s_axi_awvalid, s_axi_awready,
    input logic s_axi_bvalid, s_axi_bready, s_axi_rvalid, s_axi_rready,
    input logic s_axi_arready, adc_irq, wake_req,
    input logic [31:0] s_axi_rdata,
    input dsas_pkg::dsas_fe_t [1:0] fe
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);
    property p_bh; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
    a_bh: assert property (p_bh) else $error("bvalid dropped");
    property p_rh;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_rh: assert property (p_rh) else $error("read answer not held");
    property p_ar;
        s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
    endproperty
    a_ar: assert property (p_ar) else $error("rvalid held past rready");
    property p_aw;
        s_axi_awvalid && s_axi_awready |=> !s_axi_awready;
    endproperty
    a_aw: assert property (p_aw) else $error("awready after take");
    property p_irq; $fell(adc_irq) |-> s_axi_bvalid; endproperty
    a_irq: assert property (p_irq) else $error("irq fell alone");
    property p_tmp; !fe[1].temp_on; endproperty
    a_tmp: assert property (p_tmp) else $error("sensor on conv1");
    property p_wk; wake_req |=> !wake_req; endproperty
    a_wk: assert property (p_wk) else $error("wake not a pulse");
    property p_smp; fe[0].sample |-> fe[0].active; endproperty
    a_smp: assert property (p_smp) else $error("sample while off");
    c_irq: cover property (adc_irq);
    c_smp: cover property (fe[1].sample);
    c_rv: cover property (s_axi_rvalid);
endmodule // dsas_top_checker
bind dsas_top dsas_top_checker dsas_top_checker_i (.*);

// ===== verif/dsas_fe_model.sv
// comparator front end holding one level per input channel
// assumes fe of dsas_top; both converters see the same four levels
`timescale 1ns/100ps
module dsas_fe_model (
    input dsas_pkg::dsas_fe_t [1:0] fe,
    input logic [3:0][7:0] lvl,
    output logic [1:0] comp_in
);
    always_comb begin
        for (int k = 0; k < 2; k++) begin
            comp_in[k] = lvl[fe[k].mux] >= fe[k].dac;
        end
    end
endmodule // dsas_fe_model

// ===== verif/tb.sv
// self-checking bench of dsas_top: registers, starts, limits, dual mode
// assumes dsas_fe_model on the comparator side and the bound checker
`timescale 1ns/100ps
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin err_total++; \
    $display("unexpected at %0t: %h vs %h", $time, a, e); end end
module tb;
    logic clk_sys = 0, reset = 1, awv = 0, wv = 0, bre = 0, arv = 0, rre = 0;
    logic awr, wrd, bv, arr, rv, irq, tmr = 0, pin = 0;
    logic [7:0] aw = 8'h00, ar = 8'h00;
    logic [31:0] wd = 32'h0, rdat, d;
    logic [1:0] r, rr, cmp, br;
    logic [3:0][7:0] lvl = {8'hc3, 8'h5a, 8'h81, 8'h3c};
    dsas_pkg::dsas_fe_t [1:0] fe;
    int err_total = 0, n_tests = 0, cyc = 0;
    always #2.5 clk_sys = ~clk_sys;
    dsas_top dsas_top_i (.clk_sys(clk_sys), .reset(reset), .s_axi_awvalid(awv),
        .s_axi_awready(awr), .s_axi_awaddr(aw), .s_axi_wvalid(wv),
        .s_axi_wready(wrd), .s_axi_wdata(wd), .s_axi_wstrb(4'hf),
        .s_axi_bvalid(bv), .s_axi_bready(bre), .s_axi_bresp(br),
        .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ar),
        .s_axi_rvalid(rv), .s_axi_rready(rre), .s_axi_rdata(rdat),
        .s_axi_rresp(rr), .timer_ovf(tmr), .edge_trigger_input_pin(pin),
        .comp_in(cmp), .fe(fe), .adc_irq(irq), .wake_req());
    dsas_fe_model dsas_fe_model_i (.fe(fe), .lvl(lvl), .comp_in(cmp));
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        logic ta, tw, tb_;
        aw <= a; wd <= v; awv <= 1; wv <= 1; bre <= 1;
        do begin
            @(negedge clk_sys); ta = awv && awr; tw = wv && wrd; tb_ = bv;
            @(posedge clk_sys); if (ta) awv <= 0; if (tw) wv <= 0;
        end while (!tb_);
        bre <= 0;
        @(posedge clk_sys);
    endtask
    task automatic rd(input logic [7:0] a);
        logic ta, got;
        ar <= a; arv <= 1; rre <= 1;
        do begin
            @(negedge clk_sys); ta = arv && arr; got = rv; d = rdat; r = rr;
            @(posedge clk_sys); if (ta) arv <= 0;
        end while (!got);
        rre <= 0;
        @(posedge clk_sys);
    endtask
    task automatic go(input logic [31:0] sel, input logic [31:0] ctl);
        wr(8'h08, 32'hf3); wr(8'h04, sel); wr(8'h00, ctl);
    endtask
    task automatic wirq;
        for (int i = 0; i < 4000 && irq !== 1'b1; i++) @(negedge clk_sys);
        `CHK(irq, 1'b1)
        @(posedge clk_sys);
    endtask
    task automatic t_regs;
        rd(8'h0c); `CHK(d, 32'h0000ff00)
        rd(8'h20); `CHK(d, 32'h80808080)
        rd(8'hc0); `CHK(r, 2'h2)
        wr(8'hc0, 32'h0); `CHK(br, 2'h2)
    endtask
    task automatic t_fix;
        go(32'h0, 32'h51); wirq;
        rd(8'h10); `CHK(d, {24'h0, lvl[0]})
        wr(8'h08, 32'h1); @(negedge clk_sys); `CHK(irq, 1'b0)
    endtask
    task automatic t_start;
        go(32'h0, 32'h41); tmr <= 1; @(posedge clk_sys); tmr <= 0;
        wirq;
        go(32'h0, 32'h61); pin <= 1;
        wirq;
    endtask
    task automatic t_lim;
        wr(8'h0c, 32'h00004020); go(32'h10, 32'h191); wirq;
        rd(8'h08); `CHK(d, 32'h00000026)
        repeat (30) @(posedge clk_sys);
        rd(8'h08); `CHK(d, 32'h00000023)
    endtask
    task automatic t_scan;
        wr(8'h40, 32'h75); wr(8'h44, 32'h5);
        go(32'h5, 32'h75); wirq;
        rd(8'h58); `CHK(d, {24'h0, lvl[2]})
        rd(8'h18); `CHK(d, {24'h0, lvl[2]})
    endtask
    task automatic t_dual;
        go(32'h90, 32'h59); wirq; wr(8'h00, 32'h0);
        for (int i = 0; i < 4; i++) begin
            rd(8'h10 + 8'(4 * i));
            `CHK(d, {24'h0, lvl[1 + i % 2]})
        end
    endtask
    task automatic end_sim;
        $display("tests %0d errors %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge clk_sys);
        reset <= 0;
        t_regs; t_fix; t_start; t_lim; t_dual; t_scan;
        end_sim;
    end
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 30000) begin err_total++; end_sim; end
    end
endmodule // tb
